//--- hw/tpo_group.v
// One 4-bit output group: trigger selection and next-data transfer.
`timescale 1ns/100ps
module tpo_group (
	input wire aclk,
	input wire aresetn,
	input wire [1:0] trig_sel,
	input wire non_overlap,
	input wire [3:0] match_a,
	input wire [3:0] match_b,
	input wire [3:0] next_en,
	input wire [3:0] next_data,
	input wire [3:0] cur_data,
	output reg load,
	output reg [3:0] load_data
);
	wire ev_a;
	wire ev_b;
	wire [3:0] zero_mask;

	assign ev_a = match_a[trig_sel];
	assign ev_b = match_b[trig_sel] & non_overlap;
	assign zero_mask = next_en & ~next_data;

	always @* begin
		load = ev_a | ev_b;
		load_data = cur_data;
		if (ev_a) begin
			load_data = (cur_data & ~next_en) | (next_data & next_en);
		end else if (ev_b) begin
			load_data = cur_data & ~zero_mask;
		end
	end
endmodule

//--- hw/tpo_map.vh
// Register map, reset values, codes and group and channel counts of the timed pattern output unit.
`ifndef TPO_MAP_VH
`define TPO_MAP_VH
`define TPO_ADDR_W 8
`define TPO_OFF_PORT_DATA 8'h00
`define TPO_OFF_FUNC_HIGH 8'h04
`define TPO_OFF_FUNC_LOW 8'h08
`define TPO_OFF_NEXT_EN 8'h0c
`define TPO_OFF_NEXT_DATA 8'h10
`define TPO_OFF_TRIG_SEL 8'h14
`define TPO_OFF_MODE 8'h18
`define TPO_OFF_STATUS 8'h1c
`define TPO_FUNC_PATTERN 2'b11
`define TPO_RST_PORT_DATA 16'h0000
`define TPO_RST_FUNC 16'h0000
`define TPO_RST_NEXT_EN 16'h0000
`define TPO_RST_NEXT_DATA 16'h0000
`define TPO_RST_TRIG_SEL 8'hff
`define TPO_RST_MODE 8'hf0
`define TPO_MODE_RSVD 4'hf
`define TPO_RESP_OKAY 2'b00
`define TPO_RESP_SLVERR 2'b10
`define TPO_GROUPS 4
`define TPO_CHANNELS 4
`endif

//--- hw/tpo_top.v
// Timed pattern output unit with an AXI4-Lite register slave.
//
// Summary of operation
// - Pin drives data when function and enable set.
// - Trigger copies enabled next bits to port data.
// - Up to 16 new bits per trigger.
// - Non-overlap mode selectable per group.
// - Non-overlap: compare A copies all enabled bits.
// - Non-overlap: compare B copies only zero bits.
// - DMA writes accepted like CPU writes.
// - Ordinary mode updates only on compare A.
// - Two-bit trigger select per group, resets channel 3.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "tpo_map.vh"
module tpo_top (
	input wire aclk,
	input wire aresetn,
	input wire [`TPO_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`TPO_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [3:0] timer_match_a,
	input wire [3:0] timer_match_b,
	output reg [15:0] pattern_out,
	output reg [15:0] pattern_oe
);
	reg [15:0] port_pattern_data;
	reg [15:0] port_function_ctrl_high;
	reg [15:0] port_function_ctrl_low;
	reg [15:0] next_enable_bits;
	reg [15:0] next_pattern_data;
	reg [7:0] trigger_select_ctrl;
	reg [7:0] output_mode_ctrl;
	reg [`TPO_ADDR_W-1:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;
	reg [3:0] group_event_seen;
	wire [3:0] group_load;
	wire [15:0] group_data;
	wire [15:0] func_on;
	wire do_write;
	wire [31:0] status_word;
	genvar g;

	////////////////////////////////////////////////////////////////////////
	// Byte-lane merge shared by the five 16-bit register writes.
	// Upper lanes are ignored because no register here is wider than 16 bits.
	function [15:0] tpo_merge16;
		input [15:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			tpo_merge16 = old;
			if (strb[0]) begin
				tpo_merge16[7:0] = data[7:0];
			end
			if (strb[1]) begin
				tpo_merge16[15:8] = data[15:8];
			end
		end
	endfunction

	// A pin is in pattern mode when its two-bit function field holds the pattern code.
	function tpo_func_is_pattern;
		input [1:0] field;
		begin
			tpo_func_is_pattern = (field == `TPO_FUNC_PATTERN);
		end
	endfunction

	// An address is mapped when it names one of the eight word registers.
	function tpo_is_mapped;
		input [`TPO_ADDR_W-1:0] addr;
		begin
			case (addr)
				`TPO_OFF_PORT_DATA, `TPO_OFF_FUNC_HIGH, `TPO_OFF_FUNC_LOW, `TPO_OFF_NEXT_EN,
				`TPO_OFF_NEXT_DATA, `TPO_OFF_TRIG_SEL, `TPO_OFF_MODE, `TPO_OFF_STATUS: begin
					tpo_is_mapped = 1'b1;
				end
				default: begin
					tpo_is_mapped = 1'b0;
				end
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are taken in either order, then answered.
	// Both readies stay low while a response waits, so only one write is ever in flight
	// and the response path needs no queue.
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	// This is the single cycle in which a fully assembled write lands.
	assign do_write = aw_held & w_held & ~s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {`TPO_ADDR_W{1'b0}};
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TPO_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (tpo_is_mapped(aw_addr)) begin
					s_axi_bresp <= `TPO_RESP_OKAY;
				end else begin
					s_axi_bresp <= `TPO_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Group transfer logic, one instance per 4-bit group.
	// The timer pulses come from this clock already, so they feed the groups without a synchroniser.
	generate
		for (g = 0; g < `TPO_GROUPS; g = g + 1) begin : grp
			tpo_group u_group (
				.aclk(aclk),
				.aresetn(aresetn),
				.trig_sel(trigger_select_ctrl[2*g+1:2*g]),
				.non_overlap(output_mode_ctrl[g]),
				.match_a(timer_match_a),
				.match_b(timer_match_b),
				.next_en(next_enable_bits[4*g+3:4*g]),
				.next_data(next_pattern_data[4*g+3:4*g]),
				.cur_data(port_pattern_data[4*g+3:4*g]),
				.load(group_load[g]),
				.load_data(group_data[4*g+3:4*g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Registers. A trigger beats a software write to port data in the same cycle,
	// since losing a timed edge would corrupt the waveform.
	// A processor and a DMA engine reach the next-data registers through the same slave,
	// so both kinds of writer are served identically.
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_pattern_data <= `TPO_RST_PORT_DATA;
			port_function_ctrl_high <= `TPO_RST_FUNC;
			port_function_ctrl_low <= `TPO_RST_FUNC;
			next_enable_bits <= `TPO_RST_NEXT_EN;
			next_pattern_data <= `TPO_RST_NEXT_DATA;
			trigger_select_ctrl <= `TPO_RST_TRIG_SEL;
			output_mode_ctrl <= `TPO_RST_MODE;
			group_event_seen <= 4'h0;
		end else begin
			if (do_write) begin
				case (aw_addr)
					`TPO_OFF_PORT_DATA: begin
						port_pattern_data <= tpo_merge16(port_pattern_data, w_data, w_strb);
					end
					`TPO_OFF_FUNC_HIGH: begin
						port_function_ctrl_high <= tpo_merge16(port_function_ctrl_high, w_data, w_strb);
					end
					`TPO_OFF_FUNC_LOW: begin
						port_function_ctrl_low <= tpo_merge16(port_function_ctrl_low, w_data, w_strb);
					end
					`TPO_OFF_NEXT_EN: begin
						next_enable_bits <= tpo_merge16(next_enable_bits, w_data, w_strb);
					end
					`TPO_OFF_NEXT_DATA: begin
						next_pattern_data <= tpo_merge16(next_pattern_data, w_data, w_strb);
					end
					`TPO_OFF_TRIG_SEL: begin
						// Only the low byte lane carries the four two-bit channel selects.
						if (w_strb[0]) begin
							trigger_select_ctrl <= w_data[7:0];
						end
					end
					`TPO_OFF_MODE: begin
						// The upper four mode bits are reserved and always read as one.
						if (w_strb[0]) begin
							output_mode_ctrl <= {`TPO_MODE_RSVD, w_data[3:0]};
						end
					end
					default: begin
						port_pattern_data <= port_pattern_data;
					end
				endcase
			end
			// Status bits are sticky; a write of one clears, a new event in the same cycle wins.
			if (do_write && aw_addr == `TPO_OFF_STATUS && w_strb[0]) begin
				group_event_seen <= (group_event_seen & ~w_data[3:0]) | group_load;
			end else begin
				group_event_seen <= group_event_seen | group_load;
			end
			// A group that fires overrides only its own nibble; the other nibbles keep any
			// software write from the same cycle.
			if (group_load[0]) begin
				port_pattern_data[3:0] <= group_data[3:0];
			end
			if (group_load[1]) begin
				port_pattern_data[7:4] <= group_data[7:4];
			end
			if (group_load[2]) begin
				port_pattern_data[11:8] <= group_data[11:8];
			end
			if (group_load[3]) begin
				port_pattern_data[15:12] <= group_data[15:12];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive. The high control register holds pins 15..8, the low one pins 7..0.
	generate
		for (g = 0; g < 8; g = g + 1) begin : fn
			assign func_on[g] = tpo_func_is_pattern(port_function_ctrl_low[2*g+1:2*g]);
			assign func_on[g+8] = tpo_func_is_pattern(port_function_ctrl_high[2*g+1:2*g]);
		end
	endgenerate

	// Data and enable are both registered so that they switch on the same edge;
	// a pin never shows fresh data under a stale enable.
	always @(posedge aclk) begin
		if (!aresetn) begin
			pattern_out <= 16'h0000;
			pattern_oe <= 16'h0000;
		end else begin
			pattern_out <= port_pattern_data;
			pattern_oe <= func_on & next_enable_bits;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel.
	// Unmapped addresses answer with an error and zero data rather than aliasing a register.
	assign s_axi_arready = ~s_axi_rvalid;
	// Status reads back which groups have loaded since software last cleared them.
	assign status_word = {28'h0000000, group_event_seen};

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `TPO_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (tpo_is_mapped(s_axi_araddr)) begin
				s_axi_rresp <= `TPO_RESP_OKAY;
			end else begin
				s_axi_rresp <= `TPO_RESP_SLVERR;
			end
			case (s_axi_araddr)
				`TPO_OFF_PORT_DATA: s_axi_rdata <= {16'h0000, port_pattern_data};
				`TPO_OFF_FUNC_HIGH: s_axi_rdata <= {16'h0000, port_function_ctrl_high};
				`TPO_OFF_FUNC_LOW: s_axi_rdata <= {16'h0000, port_function_ctrl_low};
				`TPO_OFF_NEXT_EN: s_axi_rdata <= {16'h0000, next_enable_bits};
				`TPO_OFF_NEXT_DATA: s_axi_rdata <= {16'h0000, next_pattern_data};
				`TPO_OFF_TRIG_SEL: s_axi_rdata <= {24'h000000, trigger_select_ctrl};
				`TPO_OFF_MODE: s_axi_rdata <= {24'h000000, output_mode_ctrl};
				`TPO_OFF_STATUS: s_axi_rdata <= status_word;
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

//--- verif/tb_tpo_top.sv
// Self-checking bench for the timed pattern output unit.
`timescale 1ns/100ps
`include "tpo_map.vh"
module tb_tpo_top;
logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata;
logic [3:0] s_axi_wstrb, timer_match_a, timer_match_b;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [15:0] pattern_out, pattern_oe, pin_level;
integer seed = 32, errors = 0, n_checks = 0, cyc = 0;
logic [15:0] pd, en, nd;
logic [31:0] rv;
logic [1:0] rs;
tpo_top u_tpo_top (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.timer_match_a(timer_match_a), .timer_match_b(timer_match_b),
	.pattern_out(pattern_out), .pattern_oe(pattern_oe)
);
tpo_load u_tpo_load (
	.pattern_out(pattern_out), .pattern_oe(pattern_oe), .pin_level(pin_level)
);
initial begin
	aclk = 1'h0;
	forever #10 aclk = ~aclk;
end
always @(posedge aclk) begin
	cyc++;
	if (cyc == 3000) begin
		errors++;
		test_done;
	end
end
////////////////////////////////////////////////////////////////
task chk(input [31:0] seen, input [31:0] exp, input string what);
	n_checks++;
	if (seen !== exp) begin
		errors++;
		$display("ERROR %s expected %h seen %h", what, exp, seen);
	end
endtask
task wr(input [7:0] a, input [15:0] d);
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= {16'h0000, d};
	s_axi_awvalid <= 1'h1;
	s_axi_wvalid <= 1'h1;
	do begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 1'h0;
		if (s_axi_wready) s_axi_wvalid <= 1'h0;
	end while (!s_axi_bvalid);
	rs = s_axi_bresp;
endtask
task rd(input [7:0] a);
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'h1;
	do begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 1'h0;
	end while (!s_axi_rvalid);
	rv = s_axi_rdata;
	rs = s_axi_rresp;
endtask
task pulse(input [3:0] a, input [3:0] b);
	@(posedge aclk);
	timer_match_a <= a;
	timer_match_b <= b;
	@(posedge aclk);
	timer_match_a <= 4'h0;
	timer_match_b <= 4'h0;
	repeat (3) @(posedge aclk);
endtask
function [15:0] f_load(input [15:0] p, input [15:0] e, input [15:0] n, input b);
	f_load = b ? p & ~(e & ~n) : (p & ~e) | (n & e);
endfunction
task test_done;
	$display("checks %0d errors %0d", n_checks, errors);
	if (errors == 0 && n_checks > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
////////////////////////////////////////////////////////////////
initial begin
	{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn} = 4'h0;
	{s_axi_bready, s_axi_rready} = 2'h3;
	{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
	{timer_match_a, timer_match_b} = 8'h00;
	s_axi_wstrb = 4'h3;
	repeat (3) @(posedge aclk);
	aresetn <= 1'h1;
	rd(`TPO_OFF_TRIG_SEL);
	chk(rv, 32'h000000ff, "trig_sel");
	rd(`TPO_OFF_MODE);
	chk(rv, 32'h000000f0, "mode");
	rd(8'h20);
	chk(32'(rs), 32'(`TPO_RESP_SLVERR), "unmapped");
	chk(rv, 32'h00000000, "unmapped_data");
	wr(8'h20, 16'h0000);
	chk(32'(rs), 32'(`TPO_RESP_SLVERR), "wr_unmapped");
	pd = 16'($random(seed));
	en = 16'($random(seed));
	wr(`TPO_OFF_PORT_DATA, pd);
	chk(32'(rs), 32'(`TPO_RESP_OKAY), "bresp");
	wr(`TPO_OFF_FUNC_HIGH, 16'hffff);
	wr(`TPO_OFF_FUNC_LOW, 16'haaaa);
	@(posedge aclk);
	chk(32'(pattern_oe), 32'h0, "oe_off");
	wr(`TPO_OFF_NEXT_EN, en);
	repeat (2) @(posedge aclk);
	chk(32'(pin_level), 32'(pd & en & 16'hff00), "pins_code");
	wr(`TPO_OFF_FUNC_LOW, 16'hffff);
	repeat (2) @(posedge aclk);
	chk(32'(pin_level), 32'(pd & en), "pins");
	for (int ch = 0; ch < 4; ch++) begin
		wr(`TPO_OFF_TRIG_SEL, {8'h00, {4{ch[1:0]}}});
		nd = 16'($random(seed));
		wr(`TPO_OFF_NEXT_DATA, nd);
		pulse(4'h1 << ((ch + 1) % 4), 4'h1 << ch);
		chk(32'(pattern_out), 32'(pd), "idle");
		pulse(4'h1 << ch, 4'h0);
		pd = f_load(pd, en, nd, 1'h0);
		chk(32'(pattern_out), 32'(pd), "load");
	end
	rd(`TPO_OFF_STATUS);
	chk(rv, 32'h0000000f, "status");
	wr(`TPO_OFF_STATUS, 16'h000f);
	rd(`TPO_OFF_STATUS);
	chk(rv, 32'h00000000, "status_clr");
	wr(`TPO_OFF_MODE, 16'h000f);
	rd(`TPO_OFF_MODE);
	chk(rv, 32'h000000ff, "mode_set");
	nd = 16'($random(seed));
	wr(`TPO_OFF_NEXT_DATA, nd);
	pulse(4'h0, 4'h8);
	pd = f_load(pd, en, nd, 1'h1);
	chk(32'(pattern_out), 32'(pd), "zeros");
	pulse(4'h8, 4'h0);
	pd = f_load(pd, en, nd, 1'h0);
	chk(32'(pattern_out), 32'(pd), "ones");
	test_done;
end
endmodule

//--- verif/tpo_load.sv
// Behavioural pulse load seen by the pattern pins.
`timescale 1ns/100ps
module tpo_load (
	input wire logic [15:0] pattern_out,
	input wire logic [15:0] pattern_oe,
	output logic [15:0] pin_level
);
	// Undriven pins fall to the load's pull-down instead of keeping a stale level.
	assign pin_level = pattern_out & pattern_oe;
endmodule

//--- verif/tpo_top_asserts.sv
// Port-level assertions for the timed pattern output unit.
`timescale 1ns/100ps
module tpo_top_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [3:0] timer_match_a,
	input wire logic [3:0] timer_match_b,
	input wire logic [15:0] pattern_out,
	input wire logic [15:0] pattern_oe
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_wr;
	s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
property p_bresp; s_wr |-> ##2 s_axi_bvalid; endproperty
property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
property p_oe; $changed(pattern_oe) |-> $past(s_axi_bvalid); endproperty
property p_rst; $rose(aresetn) |-> pattern_oe == 16'h0000; endproperty
// Pins move only after a register write or a timer event two cycles back.
property p_out;
	$changed(pattern_out) |-> $past(s_axi_bvalid) || $past(|timer_match_a, 2) || $past(|timer_match_b, 2);
endproperty
property p_nov;
	$past(|timer_match_b, 2) && !$past(|timer_match_a, 2) && !$past(s_axi_bvalid)
		|-> (pattern_out & ~$past(pattern_out)) == 16'h0000;
endproperty
a_bresp: assert property (p_bresp) else $error("write not answered");
a_bhold: assert property (p_bhold) else $error("write answer dropped");
a_rresp: assert property (p_rresp) else $error("read not answered");
a_busy: assert property (p_busy) else $error("ready while answering");
a_oe: assert property (p_oe) else $error("enable moved without write");
a_rst: assert property (p_rst) else $error("enable after reset");
a_out: assert property (p_out) else $error("pins moved without cause");
a_nov: assert property (p_nov) else $error("compare B raised a pin");
endmodule
bind tpo_top tpo_top_asserts u_tpo_top_asserts (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.timer_match_a(timer_match_a), .timer_match_b(timer_match_b),
	.pattern_out(pattern_out), .pattern_oe(pattern_oe)
);
